//--- pkg/mscfg_defines.vh
/*
 Register numbers, fields, codes and reset values of the motor
 starter configuration bank.
 Assumes it is included by bare name.
*/
`ifndef MSCFG_DEFINES_VH
`define MSCFG_DEFINES_VH

// Register numbers on the serial link.
`define MSCFG_R_CTRL      16'h01f5
`define MSCFG_R_NETIN     16'h01f6
`define MSCFG_R_BAUD      16'h01f7
`define MSCFG_R_NODE      16'h01f8
`define MSCFG_R_PARITY    16'h01f9
`define MSCFG_R_STOP      16'h01fa
`define MSCFG_R_FRAMING   16'h01fb
`define MSCFG_R_FLA_LO    16'h0258
`define MSCFG_R_FLA_HI    16'h0259
`define MSCFG_R_FLA_SC    16'h025a
`define MSCFG_R_TRIP      16'h025b
`define MSCFG_R_VOLT      16'h025c
`define MSCFG_R_FREQ      16'h025d
`define MSCFG_R_WIRING    16'h025e
`define MSCFG_R_PHASE     16'h025f
`define MSCFG_R_METHOD    16'h0260
`define MSCFG_R_TORQUE    16'h0261
`define MSCFG_R_RAMP      16'h0262

// Control register fields and writable masks.
`define MSCFG_B_PRIMARY_RUN_COMMAND      0
`define MSCFG_B_SECONDARY_RUN_COMMAND      1
`define MSCFG_B_FRESET    3
`define MSCFG_B_ALTERNATE_RAMP_PROFILE     7
`define MSCFG_M_CTRL      8'h8b

// Value codes and limits.
`define MSCFG_BAUD_MAX    16'h0008
`define MSCFG_PAR_EVEN    8'h00
`define MSCFG_PAR_ODD     8'h01
`define MSCFG_PAR_NONE    8'h02
`define MSCFG_STOP_ONE    8'h01
`define MSCFG_STOP_TWO    8'h02
`define MSCFG_MODE_ASCII  8'h01
`define MSCFG_METH_NA     16'h0002
`define MSCFG_METH_PUMP   16'h0003
`define MSCFG_TRIP_MIN    16'h0005
`define MSCFG_TRIP_MAX    16'h001e
`define MSCFG_TORQUE_MAX  16'h0064
`define MSCFG_RAMP_MIN    16'h0005
`define MSCFG_RAMP_MAX    16'h0708

// Exception codes returned on a refused access.
`define MSCFG_EX_ADDR     8'h02
`define MSCFG_EX_VALUE    8'h03

// Reset values.
`define MSCFG_RST_BAUD    8'h03
`define MSCFG_RST_STOP    8'h01
`define MSCFG_RST_TRIP    8'h14
`define MSCFG_RST_VOLT    16'h01e0
`define MSCFG_RST_FREQ    16'h1770
`define MSCFG_RST_RAMP    16'h0064

// Clock rate in hertz.
`define MSCFG_CLK_HZ      200000000

`endif

//--- hdl/mscfg_regs.v
/*
 Configuration and control register bank of a motor soft starter,
 addressed by serial register number, with decoded outputs.
 Assumes the serial protocol engine outside presents one register
 access at a time, synchronous to clock, and waits for the answer.
*/
`include "mscfg_defines.vh"

module mscfg_regs #(
   parameter CLK_HZ      = `MSCFG_CLK_HZ, // Clock rate in hertz.
   parameter PUMP_OPTION = 1               // Pump start method fitted.
) (
   input  wire        clock,              // System clock.
   input  wire        nrst,               // Asynchronous reset, low.
   input  wire [15:0] reg_addr,           // Register number.
   input  wire        reg_wr_en,          // Write request strobe.
   input  wire        reg_rd_en,          // Read request strobe.
   input  wire [15:0] reg_wdata,          // Write data.
   input  wire [7:0]  node_address_in,    // Strapped node address.
   output reg         reg_ack,            // Answer pulse.
   output reg  [15:0] reg_rdata,          // Read data.
   output reg         reg_err,            // Access refused.
   output reg  [7:0]  reg_err_code,       // Exception code.
   output reg         primary_run_command,   // Primary run level.
   output reg         secondary_run_command, // Secondary run level.
   output reg         fault_reset_request,   // Fault reset level.
   output reg         fault_reset_pulse,     // Fault reset rising pulse.
   output reg         alternate_ramp_profile,// Alternate ramp select.
   output reg  [3:0]  network_inputs,     // Network input flags.
   output reg  [17:0] baud_bit_cycles,    // Clocks per serial bit.
   output reg         parity_enable,      // Parity bit present.
   output reg         parity_odd,         // Odd parity when enabled.
   output reg         two_stop_bits,      // Two stop bits.
   output reg         ascii_framing,      // ASCII framing, else RTU.
   output reg  [7:0]  node_address,       // Node address.
   output reg  [31:0] full_load_current,  // Float current.
   output reg  [15:0] full_load_deciamps, // Current in 0.1 A.
   output reg  [7:0]  trip_class,         // Overload trip class.
   output reg  [15:0] rated_volts,        // Nameplate volts.
   output reg  [15:0] rated_centihertz,   // Frequency in 0.01 Hz.
   output reg         inside_delta,       // Inside delta wiring.
   output reg  [7:0]  phase_order,        // Phase sequence setting.
   output reg  [1:0]  start_method,       // Start method code.
   output reg  [7:0]  initial_torque,     // Initial torque percent.
   output reg  [15:0] ramp_deciseconds    // Start ramp in 0.1 s.
);

   // Bit periods per baud code; the 32-bit quotients fit 18 bits.
   localparam [31:0] DIV0 = CLK_HZ / 1200;
   localparam [31:0] DIV1 = CLK_HZ / 2400;
   localparam [31:0] DIV2 = CLK_HZ / 4800;
   localparam [31:0] DIV3 = CLK_HZ / 9600;
   localparam [31:0] DIV4 = CLK_HZ / 19200;
   localparam [31:0] DIV5 = CLK_HZ / 38400;
   localparam [31:0] DIV6 = CLK_HZ / 57600;
   localparam [31:0] DIV7 = CLK_HZ / 115200;
   localparam [31:0] DIV8 = CLK_HZ / 230400;

   // Stored register contents.
   reg [7:0]  ctrl_q;                     // Motor control bits.
   reg [3:0]  netin_q;                    // Network input flags.
   reg [7:0]  baud_q;                     // Baud code.
   reg [7:0]  par_q;                      // Parity code.
   reg [7:0]  stop_q;                     // Stop bit code.
   reg [7:0]  mode_q;                     // Framing code.
   reg [15:0] fla_lo_q;                   // Float bytes one, zero.
   reg [15:0] fla_hi_q;                   // Float bytes three, two.
   reg [15:0] fla_sc_q;                   // Scaled current.
   reg [7:0]  trip_q;                     // Trip class.
   reg [15:0] volt_q;                     // Rated volts.
   reg [15:0] freq_q;                     // Rated frequency.
   reg        wire_q;                     // Wiring configuration.
   reg [7:0]  phase_q;                    // Phase sequence.
   reg [1:0]  meth_q;                     // Start method.
   reg [7:0]  torque_q;                   // Initial torque.
   reg [15:0] ramp_q;                     // Ramp time.
   reg [7:0]  node_q;                     // Node address.
   reg        strap_q;                    // Strap already caught.

   // Decode results for the current request.
   reg        hit;                        // Address is mapped.
   reg        val_ok;                     // Write value acceptable.
   reg        ro;                         // Register is read only.
   reg [15:0] rd_mux;                     // Read value.
   wire       req;                        // Any request this cycle.
   wire       wr_go;                      // Write will be applied.

   assign req   = reg_wr_en | reg_rd_en;
   assign wr_go = reg_wr_en & hit & ~ro & val_ok;

   // Address decode, value check and read mux. A bad value is
   // refused whole, so a setting never holds an undefined code.
   always @* begin
      hit    = 1'b1;
      ro     = 1'b0;
      val_ok = 1'b1;
      rd_mux = 16'h0000;
      case (reg_addr)
         `MSCFG_R_CTRL: begin
            rd_mux = {8'h00, ctrl_q};
         end
         `MSCFG_R_NETIN: begin
            rd_mux = {12'h000, netin_q};
         end
         `MSCFG_R_BAUD: begin
            rd_mux = {8'h00, baud_q};
            // Code 0x09 has no rate and is refused.
            val_ok = (reg_wdata <= `MSCFG_BAUD_MAX);
         end
         `MSCFG_R_NODE: begin
            rd_mux = {8'h00, node_q};
            ro     = 1'b1;
         end
         `MSCFG_R_PARITY: begin
            rd_mux = {8'h00, par_q};
            val_ok = (reg_wdata <= {8'h00, `MSCFG_PAR_NONE});
         end
         `MSCFG_R_STOP: begin
            rd_mux = {8'h00, stop_q};
            val_ok = (reg_wdata == {8'h00, `MSCFG_STOP_ONE}) |
                     (reg_wdata == {8'h00, `MSCFG_STOP_TWO});
         end
         `MSCFG_R_FRAMING: begin
            rd_mux = {8'h00, mode_q};
            val_ok = (reg_wdata <= {8'h00, `MSCFG_MODE_ASCII});
         end
         `MSCFG_R_FLA_LO: rd_mux = fla_lo_q;
         `MSCFG_R_FLA_HI: rd_mux = fla_hi_q;
         `MSCFG_R_FLA_SC: rd_mux = fla_sc_q;
         `MSCFG_R_TRIP: begin
            rd_mux = {8'h00, trip_q};
            val_ok = (reg_wdata >= `MSCFG_TRIP_MIN) &
                     (reg_wdata <= `MSCFG_TRIP_MAX);
         end
         `MSCFG_R_VOLT: begin
            rd_mux = volt_q;
         end
         `MSCFG_R_FREQ: begin
            rd_mux = freq_q;
         end
         `MSCFG_R_WIRING: begin
            rd_mux = {15'h0000, wire_q};
            val_ok = (reg_wdata <= 16'h0001);
         end
         `MSCFG_R_PHASE: begin
            rd_mux = {8'h00, phase_q};
            val_ok = (reg_wdata <= 16'h0001);
         end
         `MSCFG_R_METHOD: begin
            rd_mux = {14'h0000, meth_q};
            // Pump start is only offered when the option is fitted.
            val_ok = (reg_wdata <= `MSCFG_METH_PUMP) &
                     (reg_wdata != `MSCFG_METH_NA) &
                     ((reg_wdata != `MSCFG_METH_PUMP) |
                      (PUMP_OPTION != 0));
         end
         `MSCFG_R_TORQUE: begin
            rd_mux = {8'h00, torque_q};
            val_ok = (reg_wdata <= `MSCFG_TORQUE_MAX);
         end
         `MSCFG_R_RAMP: begin
            rd_mux = ramp_q;
            val_ok = (reg_wdata >= `MSCFG_RAMP_MIN) &
                     (reg_wdata <= `MSCFG_RAMP_MAX);
         end
         default: begin
            hit = 1'b0;                  // Unmapped number.
         end
      endcase
   end

   // Register storage. Writes land on the request edge.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl_q   <= 8'h00;
         netin_q  <= 4'h0;
         baud_q   <= `MSCFG_RST_BAUD;
         par_q    <= `MSCFG_PAR_EVEN;
         stop_q   <= `MSCFG_RST_STOP;
         mode_q   <= 8'h00;
         fla_lo_q <= 16'h0000;
         fla_hi_q <= 16'h0000;
         fla_sc_q <= 16'h0000;
         trip_q   <= `MSCFG_RST_TRIP;
         volt_q   <= `MSCFG_RST_VOLT;
         freq_q   <= `MSCFG_RST_FREQ;
         wire_q   <= 1'b0;
         phase_q  <= 8'h00;
         meth_q   <= 2'h0;
         torque_q <= 8'h00;
         ramp_q   <= `MSCFG_RST_RAMP;
      end else if (wr_go) begin
         case (reg_addr)
            `MSCFG_R_CTRL: begin
               // Reserved bits never store.
               ctrl_q <= reg_wdata[7:0] & `MSCFG_M_CTRL;
            end
            `MSCFG_R_NETIN: begin
               netin_q <= reg_wdata[3:0];
            end
            `MSCFG_R_BAUD: begin
               baud_q <= reg_wdata[7:0];
            end
            `MSCFG_R_PARITY: begin
               par_q <= reg_wdata[7:0];
            end
            `MSCFG_R_STOP: begin
               stop_q <= reg_wdata[7:0];
            end
            `MSCFG_R_FRAMING: begin
               mode_q <= reg_wdata[7:0];
            end
            `MSCFG_R_FLA_LO: begin
               fla_lo_q <= reg_wdata;
            end
            `MSCFG_R_FLA_HI: begin
               fla_hi_q <= reg_wdata;
            end
            `MSCFG_R_FLA_SC: begin
               fla_sc_q <= reg_wdata;
            end
            `MSCFG_R_TRIP: begin
               trip_q <= reg_wdata[7:0];
            end
            `MSCFG_R_VOLT: begin
               volt_q <= reg_wdata;
            end
            `MSCFG_R_FREQ: begin
               freq_q <= reg_wdata;
            end
            `MSCFG_R_WIRING: begin
               wire_q <= reg_wdata[0];
            end
            `MSCFG_R_PHASE: begin
               phase_q <= reg_wdata[7:0];
            end
            `MSCFG_R_METHOD: begin
               meth_q <= reg_wdata[1:0];
            end
            `MSCFG_R_TORQUE: begin
               torque_q <= reg_wdata[7:0];
            end
            `MSCFG_R_RAMP: begin
               ramp_q <= reg_wdata;
            end
            default: begin
               ctrl_q <= ctrl_q;          // Nothing else is writable.
            end
         endcase
      end
   end

   // Node address is a strap caught once after reset release; the
   // link can never change it.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         node_q  <= 8'h00;
         strap_q <= 1'b0;
      end else if (!strap_q) begin
         node_q  <= node_address_in;
         strap_q <= 1'b1;
      end
   end

   // Answer one cycle after each request.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         reg_ack      <= 1'b0;
         reg_rdata    <= 16'h0000;
         reg_err      <= 1'b0;
         reg_err_code <= 8'h00;
      end else begin
         reg_ack <= req;
         // Write takes priority when both strobes are high.
         reg_rdata <= (req & ~reg_wr_en & hit) ? rd_mux : 16'h0000;
         if (req & (~hit | (reg_wr_en & ro))) begin
            reg_err      <= 1'b1;
            reg_err_code <= `MSCFG_EX_ADDR;
         end else if (reg_wr_en & ~val_ok) begin
            reg_err      <= 1'b1;
            reg_err_code <= `MSCFG_EX_VALUE;
         end else begin
            reg_err      <= 1'b0;
            reg_err_code <= 8'h00;
         end
      end
   end

   // Decoded outputs, one cycle behind the stored values so that
   // every output leaves a flip-flop.
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         primary_run_command    <= 1'b0;
         secondary_run_command  <= 1'b0;
         fault_reset_request    <= 1'b0;
         fault_reset_pulse      <= 1'b0;
         alternate_ramp_profile <= 1'b0;
         network_inputs         <= 4'h0;
         baud_bit_cycles        <= DIV3[17:0];
         parity_enable          <= 1'b1;
         parity_odd             <= 1'b0;
         two_stop_bits          <= 1'b0;
         ascii_framing          <= 1'b0;
         node_address           <= 8'h00;
         full_load_current      <= 32'h0000_0000;
         full_load_deciamps     <= 16'h0000;
         trip_class             <= 8'h00;
         rated_volts            <= 16'h0000;
         rated_centihertz       <= 16'h0000;
         inside_delta           <= 1'b0;
         phase_order            <= 8'h00;
         start_method           <= 2'h0;
         initial_torque         <= 8'h00;
         ramp_deciseconds       <= 16'h0000;
      end else begin
         // Run commands follow the held level.
         primary_run_command   <= ctrl_q[`MSCFG_B_PRIMARY_RUN_COMMAND];
         secondary_run_command <= ctrl_q[`MSCFG_B_SECONDARY_RUN_COMMAND];
         fault_reset_request   <= ctrl_q[`MSCFG_B_FRESET];
         fault_reset_pulse     <= ctrl_q[`MSCFG_B_FRESET] &
                                  ~fault_reset_request;
         alternate_ramp_profile <= ctrl_q[`MSCFG_B_ALTERNATE_RAMP_PROFILE];
         network_inputs <= netin_q;
         case (baud_q)
            8'h00: baud_bit_cycles <= DIV0[17:0];
            8'h01: baud_bit_cycles <= DIV1[17:0];
            8'h02: baud_bit_cycles <= DIV2[17:0];
            8'h03: baud_bit_cycles <= DIV3[17:0];
            8'h04: baud_bit_cycles <= DIV4[17:0];
            8'h05: baud_bit_cycles <= DIV5[17:0];
            8'h06: baud_bit_cycles <= DIV6[17:0];
            8'h07: baud_bit_cycles <= DIV7[17:0];
            default: baud_bit_cycles <= DIV8[17:0];
         endcase
         parity_enable <= (par_q != `MSCFG_PAR_NONE);
         parity_odd    <= (par_q == `MSCFG_PAR_ODD);
         two_stop_bits <= (stop_q == `MSCFG_STOP_TWO);
         ascii_framing <= (mode_q == `MSCFG_MODE_ASCII);
         node_address  <= node_q;
         // Low word holds bytes one and zero.
         full_load_current  <= {fla_hi_q, fla_lo_q};
         full_load_deciamps <= fla_sc_q;
         trip_class         <= trip_q;
         rated_volts        <= volt_q;
         rated_centihertz   <= freq_q;
         inside_delta       <= wire_q;
         phase_order        <= phase_q;
         start_method       <= meth_q;
         initial_torque     <= torque_q;
         ramp_deciseconds   <= ramp_q;
      end
   end

endmodule // mscfg_regs

//--- bench/mscfg_chk.sv
/* Checker of the motor starter configuration register bank.
   Assumes it is bound into mscfg_regs and sees only its ports. */
module mscfg_chk (
   input wire logic        clock,                 // System clock.
   input wire logic        nrst,                  // Reset, low.
   input wire logic [15:0] reg_addr,              // Register number.
   input wire logic        reg_wr_en,             // Write strobe.
   input wire logic        reg_rd_en,             // Read strobe.
   input wire logic [15:0] reg_wdata,             // Write data.
   input wire logic        reg_ack,               // Answer pulse.
   input wire logic [15:0] reg_rdata,             // Read data.
   input wire logic        reg_err,               // Refusal.
   input wire logic [7:0]  reg_err_code,          // Exception code.
   input wire logic        primary_run_command,   // Run level one.
   input wire logic        secondary_run_command, // Run level two.
   input wire logic        fault_reset_request,   // Fault reset level.
   input wire logic        fault_reset_pulse,     // Fault reset pulse.
   input wire logic        alternate_ramp_profile,// Ramp select.
   input wire logic [3:0]  network_inputs,        // Network flags.
   input wire logic        parity_enable,         // Parity present.
   input wire logic        parity_odd,            // Odd parity.
   input wire logic        two_stop_bits          // Two stop bits.
);
   timeunit 1ns;
   timeprecision 100ps;
   // One clock domain, so clock and reset are given once here.
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   // Decoded levels lag a write by two edges, hence a depth of two.
   ack_follows_a: assert property ((reg_wr_en || reg_rd_en) |=> reg_ack)
      else $error("no answer");
   idle_quiet_a: assert property (!(reg_wr_en || reg_rd_en) |=> !reg_ack && reg_rdata == 16'h0000)
      else $error("stray answer");
   run_levels_a: assert property (reg_wr_en && reg_addr == 16'h01f5 |=> ##1
      {secondary_run_command, primary_run_command} == $past(reg_wdata[1:0], 2)) else $error("run levels wrong");
   ramp_select_a: assert property (reg_wr_en && reg_addr == 16'h01f5 |=> ##1
      alternate_ramp_profile == $past(reg_wdata[7], 2)) else $error("ramp select wrong");
   fault_pulse_a: assert property (fault_reset_pulse |-> fault_reset_request && !$past(fault_reset_request))
      else $error("stray fault pulse");
   reserved_zero_a: assert property (reg_rd_en && !reg_wr_en && reg_addr == 16'h01f5 |=>
      reg_rdata[6:4] == 3'h0 && !reg_rdata[2]) else $error("reserved bits read set");
   net_flags_a: assert property (reg_wr_en && reg_addr == 16'h01f6 |=> ##1
      network_inputs == $past(reg_wdata[3:0], 2)) else $error("network flags wrong");
   baud_refuse_a: assert property (reg_wr_en && reg_addr == 16'h01f7 && reg_wdata > 16'h0008 |=>
      reg_err && reg_err_code == 8'h03) else $error("bad rate code taken");
   parity_dec_a: assert property (reg_wr_en && reg_addr == 16'h01f9 && reg_wdata <= 16'h0002 |=> ##1
      parity_enable == ($past(reg_wdata, 2) != 16'h0002) && parity_odd == ($past(reg_wdata, 2) == 16'h0001))
      else $error("parity decode wrong");
   stop_dec_a: assert property (reg_wr_en && reg_addr == 16'h01fa && reg_wdata inside {16'h0001, 16'h0002}
      |=> ##1 two_stop_bits == ($past(reg_wdata, 2) == 16'h0002)) else $error("stop decode wrong");
   node_ro_a: assert property (reg_wr_en && reg_addr == 16'h01f8 |=> reg_err && reg_err_code == 8'h02)
      else $error("node address write taken");
   trip_limit_a: assert property (reg_wr_en && reg_addr == 16'h025b && reg_wdata > 16'h001e |=>
      reg_err && reg_err_code == 8'h03) else $error("trip class over limit");
endmodule // mscfg_chk

bind mscfg_regs mscfg_chk i_chk (.clock, .nrst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata, .reg_ack, .reg_rdata,
   .reg_err, .reg_err_code, .primary_run_command, .secondary_run_command, .fault_reset_request, .fault_reset_pulse,
   .alternate_ramp_profile, .network_inputs, .parity_enable, .parity_odd, .two_stop_bits);

//--- bench/mscfg_master.sv
/* Model of the serial master that reaches the register bank.
   Assumes callers hand it one request per clock edge. */
module mscfg_master (
   input  wire logic   clock,     // System clock.
   output logic [15:0] reg_addr,  // Register number.
   output logic        reg_wr_en, // Write strobe.
   output logic        reg_rd_en, // Read strobe.
   output logic [15:0] reg_wdata  // Write data.
);
   timeunit 1ns;
   timeprecision 100ps;
   // Quiet bus at time zero.
   initial begin
      reg_addr = 16'h0000;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = 16'h0000;
   end

   // One word per request, so float halves travel separately.
   task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr_en <= wr;
      reg_rd_en <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
   endtask

   // Released lines show inverted data so stale values cannot pass.
   task automatic idle();
      @(posedge clock);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_addr <= ~reg_addr;
      reg_wdata <= ~reg_wdata;
   endtask
endmodule // mscfg_master

//--- bench/tb_top.sv
/* Self-checking bench of the configuration register bank.
   Assumes mscfg_regs, its bound checker and the master model. */
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CLK = 200000000; // Clock rate in hertz.
   localparam logic [15:0] AD [18] = '{16'h01f5, 16'h01f6, 16'h01f7, 16'h01f8, 16'h01f9, 16'h01fa, 16'h01fb,
      16'h0258, 16'h0259, 16'h025a, 16'h025b, 16'h025c, 16'h025d, 16'h025e, 16'h025f, 16'h0260, 16'h0261, 16'h0262};
   localparam logic [15:0] RV [18] = '{16'h0000, 16'h0000, 16'h0003, 16'h002a, 16'h0000, 16'h0001, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h0014, 16'h01e0, 16'h1770, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064};
   localparam int TA [15] = '{0, 1, 2, 3, 4, 5, 6, 10, 10, 13, 14, 15, 16, 17, 17}; // Indices into AD.
   localparam int TL [15] = '{0, 0, 0, 0, 0, 0, 0, 4, 29, 0, 0, 0, 99, 4, 1799};
   localparam int TH [15] = '{255, 31, 9, 1, 3, 3, 2, 5, 31, 2, 2, 3, 101, 5, 1801};
   localparam logic [15:0] MK [4] = '{16'h000f, 16'h003f, 16'h07ff, 16'hffff};
   logic clock = 1'b0;                 // System clock.
   logic nrst = 1'b0;                  // Reset, active low.
   logic [7:0] node_address_in = 8'h2a; // Strap, as RV expects.
   wire [15:0] reg_addr, reg_wdata, reg_rdata, full_load_deciamps, rated_volts, rated_centihertz, ramp_deciseconds;
   wire reg_wr_en, reg_rd_en, reg_ack, reg_err, primary_run_command, secondary_run_command, fault_reset_request;
   wire fault_reset_pulse, alternate_ramp_profile, parity_enable, parity_odd, two_stop_bits, ascii_framing;
   wire inside_delta;
   wire [7:0] reg_err_code, node_address, trip_class, phase_order, initial_torque;
   wire [3:0] network_inputs;
   wire [17:0] baud_bit_cycles;
   wire [31:0] full_load_current;
   wire [1:0] start_method;
   int fails = 0;                      // Mismatches seen.
   int samples_checked = 0;            // Comparisons made.
   logic [24:0] q[$];                  // Expected answers {err, code, data}.
   logic [15:0] mem [logic [15:0]];    // Register model.
   logic [31:0] lfsr = 32'h0001_75ec;  // Random source.
   logic [15:0] ra;                    // Random register number.

   always #2.5 clock = ~clock;

   mscfg_master i_mst (.clock, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata);
   mscfg_regs #(.CLK_HZ(CLK), .PUMP_OPTION(1)) i_dut (.clock, .nrst, .reg_addr, .reg_wr_en, .reg_rd_en,
      .reg_wdata, .node_address_in, .reg_ack, .reg_rdata, .reg_err, .reg_err_code, .primary_run_command,
      .secondary_run_command, .fault_reset_request, .fault_reset_pulse, .alternate_ramp_profile,
      .network_inputs, .baud_bit_cycles, .parity_enable, .parity_odd, .two_stop_bits, .ascii_framing,
      .node_address, .full_load_current, .full_load_deciamps, .trip_class, .rated_volts, .rated_centihertz,
      .inside_delta, .phase_order, .start_method, .initial_torque, .ramp_deciseconds);

   task automatic check(string what, logic [191:0] seen, logic [191:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   function automatic logic [15:0] m(logic [11:0] a);
      return mem[{4'h0, a}];
   endfunction

   // Maximal-length stimulus shift register.
   function automatic logic [31:0] lfsr_next(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Clock cycles per bit for an accepted rate code.
   function automatic logic [17:0] div(logic [15:0] c);
      int r [9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400};
      return 18'(CLK / r[c[3:0]]);
   endfunction

   // Exception code expected for a write; bad values are refused.
   function automatic logic [7:0] code_of(logic [15:0] a, logic [15:0] d);
      logic ok;
      if (!mem.exists(a) || a == 16'h01f8) return 8'h02;
      case (a)
         16'h01f7: ok = d <= 16'h0008;
         16'h01f9: ok = d <= 16'h0002;
         16'h01fa: ok = d == 16'h0001 || d == 16'h0002;
         16'h01fb, 16'h025e, 16'h025f: ok = d <= 16'h0001;
         16'h025b: ok = d >= 16'h0005 && d <= 16'h001e;
         16'h0260: ok = d <= 16'h0003 && d != 16'h0002;
         16'h0261: ok = d <= 16'h0064;
         16'h0262: ok = d >= 16'h0005 && d <= 16'h0708;
         default: ok = 1'b1;
      endcase
      return ok ? 8'h00 : 8'h03;
   endfunction

   // Write and note the answer; reserved control bits are dropped.
   task automatic put(logic [15:0] a, logic [15:0] d);
      logic [7:0] c;
      c = code_of(a, d);
      i_mst.access(1'b1, a, d);
      q.push_back({c != 8'h00, c, 16'h0000});
      if (c == 8'h00) mem[a] = a == 16'h01f5 ? d & 16'h008b : a == 16'h01f6 ? d & 16'h000f : d;
   endtask

   task automatic get(logic [15:0] a);
      i_mst.access(1'b0, a, 16'h0000);
      q.push_back(mem.exists(a) ? {1'b0, 8'h00, mem[a]} : {1'b1, 8'h02, 16'h0000});
   endtask

   // Quiet bus, then compare every decoded output except fault_reset_pulse with the model.
   task automatic outs();
      logic [15:0] c;
      c = m(12'h1f5);
      repeat (3) i_mst.idle();
      @(negedge clock);
      check("outputs", {primary_run_command, secondary_run_command, fault_reset_request,
         alternate_ramp_profile, network_inputs, baud_bit_cycles, parity_enable, parity_odd, two_stop_bits,
         ascii_framing, node_address, full_load_current, full_load_deciamps, trip_class, rated_volts,
         rated_centihertz, inside_delta, phase_order, start_method, initial_torque, ramp_deciseconds},
         {c[0], c[1], c[3], c[7], 4'(m(12'h1f6)), div(m(12'h1f7)), m(12'h1f9) != 16'h0002, m(12'h1f9) == 16'h0001,
         m(12'h1fa) == 16'h0002, m(12'h1fb) == 16'h0001, 8'(m(12'h1f8)), m(12'h259), m(12'h258), m(12'h25a),
         8'(m(12'h25b)), m(12'h25c), m(12'h25d), 1'(m(12'h25e)), 8'(m(12'h25f)), 2'(m(12'h260)), 8'(m(12'h261)),
         m(12'h262)});
   endtask

   // Each answer is compared with the oldest note.
   always @(negedge clock) begin
      if (reg_ack === 1'b1) begin
         if (q.size() == 0)
            check("unasked answer", 192'h0, 192'h1);
         else
            check("answer", {reg_err, reg_err_code, reg_rdata}, q.pop_front());
      end
   end

   initial begin
      repeat (100000) @(posedge clock);
      fails++;
      stop_test();
   end

   // Two passes, so the second reset lands in mid-run.
   initial begin
      for (int p = 0; p < 2; p++) begin
         @(posedge clock);
         nrst <= 1'b0;
         repeat (6) @(posedge clock);
         nrst <= 1'b1;
         foreach (AD[i]) mem[AD[i]] = RV[i];
         repeat (2) i_mst.idle();
         foreach (AD[i]) get(AD[i]);
         get(16'h01f4);
         get(16'h0263);
         outs();
         foreach (TA[i]) for (int d = TL[i]; d <= TH[i]; d++) begin
            put(AD[TA[i]], 16'(d));
            outs();
            get(AD[TA[i]]);
         end
         repeat (400) begin
            lfsr = lfsr_next(lfsr);
            ra = lfsr[5:4] == 2'h0 ? {7'h00, lfsr[8:0]} : AD[lfsr[14:10] % 18];
            if (lfsr[9])
               put(ra, lfsr[31:16] & MK[lfsr[7:6]]);
            else
               get(ra);
         end
         outs();
      end
      check("pending", 192'(q.size()), 192'h0);
      stop_test();
   end
endmodule // tb_top
